// ===== core/cyclic_cfg_params.svh
// offsets, field positions, reset values and timing counts for the cyclic timer config block
`ifndef CYCLIC_CFG_PARAMS_SVH
`define CYCLIC_CFG_PARAMS_SVH

`define CT_ADDR_TIMER      7'h0c
`define CT_ADDR_HWCFG      7'h0e
`define CT_ADDR_W          7

`define CT_ON_HI           6
`define CT_ON_LO           4
`define CT_PER_HI          3
`define CT_PER_LO          0
`define CT_HYS_BIT         7
`define CT_TSD_BIT         5
`define CT_RDEL_BIT        4
`define CT_LOCK0_BIT       3

`define CT_TIMER_RST       8'h00
`define CT_HWCFG_RST       8'h00
`define CT_GPIO_CYC_SENSE  3'h3

`define CT_SPI_FRAME_BITS  5'h10
`define CT_SPI_ADDR_BITS   5'h08
`define CT_SPI_WR_BIT      7
`define CT_SPI_IDLE_PINS   3'h4

`define CT_CLK_PERIOD_PS   4000
`define CT_TICK_US         100
`define CT_TICK_CYCLES     ((`CT_TICK_US * 1000 * 1000) / `CT_CLK_PERIOD_PS)

`define CT_ON1_US          100
`define CT_ON2_US          300
`define CT_ON3_US          1000
`define CT_ON4_US          10000
`define CT_ON5_US          20000

`define CT_PER0_MS         10
`define CT_PER1_MS         20
`define CT_PER2_MS         50
`define CT_PER3_MS         100
`define CT_PER4_MS         200
`define CT_PER5_MS         500
`define CT_PER6_MS         1000
`define CT_PER7_MS         2000
`define CT_PER8_MS         5000
`define CT_PER9_MS         10000
`define CT_PER10_MS        20000
`define CT_PER11_MS        50000
`define CT_PER12_MS        100000
`define CT_PER13_MS        200000
`define CT_PER14_MS        500000
`define CT_PER15_MS        1000000

`endif

// ===== core/cyclic_cfg_pkg.sv
// types shared by the cyclic timer config block
package cyclic_cfg_pkg;

	typedef enum logic [2:0] {
		ON_OFF_LOW  = 3'h0,
		ON_T1       = 3'h1,
		ON_T2       = 3'h2,
		ON_T3       = 3'h3,
		ON_T4       = 3'h4,
		ON_T5       = 3'h5,
		ON_OFF_HIGH = 3'h6,
		ON_RESERVED = 3'h7
	} on_code_t;

	typedef enum logic [3:0] {
		GEN_IDLE_LOW  = 4'b0001,
		GEN_IDLE_HIGH = 4'b0010,
		GEN_ON_PHASE  = 4'b0100,
		GEN_OFF_PHASE = 4'b1000
	} gen_state_t;

endpackage : cyclic_cfg_pkg

// ===== core/cyclic_wave_gen.sv
// cyclic timer waveform generator driving the high-side output
`timescale 1ns/1ps
`include "cyclic_cfg_params.svh"

module cyclic_wave_gen #(
	parameter int TICK_CYCLES = `CT_TICK_CYCLES
) (
	input  wire logic       clock_in,
	input  wire logic       rst_n_in,
	input  wire logic       run_in,
	input  wire logic       restart_in,
	input  wire logic [2:0] on_code_in,
	input  wire logic [3:0] per_code_in,
	output logic            high_side_out,
	output logic            period_start_out
);

	cyclic_cfg_pkg::gen_state_t state_ff;
	cyclic_cfg_pkg::gen_state_t nxt_state;
	logic [14:0]                pre_ff;
	logic [23:0]                cnt_ff;
	logic [23:0]                nxt_cnt;
	logic                       tick;
	logic                       running_code;
	logic                       start_ff;

	function automatic logic [23:0] on_ticks(input logic [2:0] code);
		int us;
		us = 0;
		case (code)
			3'h1: us = `CT_ON1_US;
			3'h2: us = `CT_ON2_US;
			3'h3: us = `CT_ON3_US;
			3'h4: us = `CT_ON4_US;
			3'h5: us = `CT_ON5_US;
			default: us = 0;
		endcase
		return 24'(us / `CT_TICK_US);
	endfunction : on_ticks

	function automatic logic [23:0] per_ticks(input logic [3:0] code);
		int ms;
		ms = 0;
		case (code)
			4'h0: ms = `CT_PER0_MS;
			4'h1: ms = `CT_PER1_MS;
			4'h2: ms = `CT_PER2_MS;
			4'h3: ms = `CT_PER3_MS;
			4'h4: ms = `CT_PER4_MS;
			4'h5: ms = `CT_PER5_MS;
			4'h6: ms = `CT_PER6_MS;
			4'h7: ms = `CT_PER7_MS;
			4'h8: ms = `CT_PER8_MS;
			4'h9: ms = `CT_PER9_MS;
			4'ha: ms = `CT_PER10_MS;
			4'hb: ms = `CT_PER11_MS;
			4'hc: ms = `CT_PER12_MS;
			4'hd: ms = `CT_PER13_MS;
			4'he: ms = `CT_PER14_MS;
			default: ms = `CT_PER15_MS;
		endcase
		return 24'((ms * 1000) / `CT_TICK_US);
	endfunction : per_ticks

	// codes 001..101 run; 101 taken as the 20 ms on-time
	assign running_code = (on_code_in != 3'h0) && (on_code_in < 3'h6);
	assign tick         = (pre_ff == 15'(TICK_CYCLES - 1));
	assign nxt_cnt      = cnt_ff + 24'h00_0001;

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pre_ff <= 15'h0000;
		end else if (restart_in || tick) begin
			pre_ff <= 15'h0000;
		end else begin
			pre_ff <= pre_ff + 15'h0001;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		if (on_code_in == 3'h6) begin
			nxt_state = cyclic_cfg_pkg::GEN_IDLE_HIGH;
		end else if (!running_code || !run_in) begin
			nxt_state = cyclic_cfg_pkg::GEN_IDLE_LOW;
		end else if (restart_in) begin
			nxt_state = cyclic_cfg_pkg::GEN_ON_PHASE;
		end else begin
			unique case (state_ff)
				cyclic_cfg_pkg::GEN_IDLE_LOW,
				cyclic_cfg_pkg::GEN_IDLE_HIGH: nxt_state = cyclic_cfg_pkg::GEN_ON_PHASE;
				cyclic_cfg_pkg::GEN_ON_PHASE: begin
					if (tick && nxt_cnt >= per_ticks(per_code_in)) begin
						nxt_state = cyclic_cfg_pkg::GEN_ON_PHASE;
					end else if (tick && nxt_cnt >= on_ticks(on_code_in)) begin
						nxt_state = cyclic_cfg_pkg::GEN_OFF_PHASE;
					end
				end
				cyclic_cfg_pkg::GEN_OFF_PHASE: begin
					if (tick && nxt_cnt >= per_ticks(per_code_in)) begin
						nxt_state = cyclic_cfg_pkg::GEN_ON_PHASE;
					end
				end
				default: nxt_state = cyclic_cfg_pkg::GEN_IDLE_LOW;
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_ff <= cyclic_cfg_pkg::GEN_IDLE_LOW;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// counter restarts with each period, so the on phase always leads it
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_ff   <= 24'h00_0000;
			start_ff <= 1'b0;
		end else if (nxt_state != cyclic_cfg_pkg::GEN_ON_PHASE &&
		             nxt_state != cyclic_cfg_pkg::GEN_OFF_PHASE) begin
			cnt_ff   <= 24'h00_0000;
			start_ff <= 1'b0;
		end else if (restart_in || state_ff == cyclic_cfg_pkg::GEN_IDLE_LOW ||
		             state_ff == cyclic_cfg_pkg::GEN_IDLE_HIGH) begin
			cnt_ff   <= 24'h00_0000;
			start_ff <= 1'b1;
		end else if (tick && nxt_cnt >= per_ticks(per_code_in)) begin
			cnt_ff   <= 24'h00_0000;
			start_ff <= 1'b1;
		end else begin
			cnt_ff   <= tick ? nxt_cnt : cnt_ff;
			start_ff <= 1'b0;
		end
	end

	assign high_side_out    = (state_ff == cyclic_cfg_pkg::GEN_ON_PHASE) ||
	                          (state_ff == cyclic_cfg_pkg::GEN_IDLE_HIGH);
	assign period_start_out = start_ff;

endmodule : cyclic_wave_gen

// ===== core/cyclic_timer_and_hw_lock_cfg.sv
// cyclic timer and hardware lock configuration registers behind the spi control port
`timescale 1ns/1ps
`include "cyclic_cfg_params.svh"

module cyclic_timer_and_hw_lock_cfg #(
	parameter int TICK_CYCLES = `CT_TICK_CYCLES
) (
	input  wire logic       clock_in,
	input  wire logic       rst_n_in,
	input  wire logic       chip_select_n_in,
	input  wire logic       spi_clk_in,
	input  wire logic       spi_mosi_in,
	output logic            spi_miso_out,
	output logic            spi_miso_en_out,
	input  wire logic       timer_assigned_in,
	input  wire logic       timer_wake_enable_in,
	input  wire logic       restart_mode_in,
	input  wire logic       soft_reset_in,
	input  wire logic [2:0] gpio_config_in,
	input  wire logic       gpio_high_side_cleared_in,
	input  wire logic       lock_one_in,
	output logic            high_side_output_out,
	output logic            cyclic_wake_tick_out,
	output logic            cyclic_sense_active_out,
	output logic            undervoltage_release_hysteresis_out,
	output logic            overtemp_retry_extension_out,
	output logic            reset_delay_select_out,
	output logic            level0_lock_out,
	output logic            level1_lock_active_out,
	output logic            protected_write_enable_out
);

	// pin synchronisers: cs_n, sclk, mosi
	logic [2:0] pin_s1_ff;
	logic [2:0] pin_s2_ff;
	logic [2:0] pin_s3_ff;
	logic [2:0] pin_filt_ff;
	logic [2:0] pin_prev_ff;
	logic       cs_active;
	logic       cs_rise;
	logic       sclk_rise;
	logic       sclk_fall;

	logic [15:0] shift_ff;
	logic [4:0]  bit_cnt_ff;
	logic [7:0]  rd_data_ff;
	logic [7:0]  rd_sel;
	logic        miso_ff;
	logic [7:0]  timer_ff;
	logic [7:0]  hwcfg_ff;
	logic [7:0]  nxt_timer;
	logic [7:0]  nxt_hwcfg;
	logic        lock_one_eff_ff;
	logic        wr_commit;
	logic [6:0]  wr_addr;
	logic [7:0]  wr_data;
	logic        sense_clear;
	logic        timer_changed_ff;
	logic        gen_high;
	logic        gen_start;
	logic        cyc_sense_sel;

	function automatic logic [7:0] read_mux(input logic [6:0] addr,
	                                        input logic [7:0] tmr,
	                                        input logic [7:0] hw);
		logic [7:0] val;
		val = 8'h00;
		if (addr == `CT_ADDR_TIMER) begin
			val = tmr;
		end else if (addr == `CT_ADDR_HWCFG) begin
			val = hw;
		end
		return val;
	endfunction : read_mux

	// three stages; a level counts once stages two and three agree
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_s1_ff <= `CT_SPI_IDLE_PINS;
			pin_s2_ff <= `CT_SPI_IDLE_PINS;
			pin_s3_ff <= `CT_SPI_IDLE_PINS;
		end else begin
			pin_s1_ff <= {chip_select_n_in, spi_clk_in, spi_mosi_in};
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_filt_ff <= `CT_SPI_IDLE_PINS;
			pin_prev_ff <= `CT_SPI_IDLE_PINS;
		end else begin
			pin_filt_ff <= (pin_s2_ff & pin_s3_ff) | (pin_filt_ff & (pin_s2_ff ^ pin_s3_ff));
			pin_prev_ff <= pin_filt_ff;
		end
	end

	// edges come from filtered levels, so one-sample glitches never count
	assign cs_active = !pin_filt_ff[2];
	assign cs_rise   = pin_filt_ff[2] && !pin_prev_ff[2];
	assign sclk_rise = cs_active && pin_filt_ff[1] && !pin_prev_ff[1];
	assign sclk_fall = cs_active && !pin_filt_ff[1] && pin_prev_ff[1];

	// lsb first: address 6:0, write flag bit 7, then data byte
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			shift_ff <= 16'h0000;
		end else if (sclk_rise) begin
			shift_ff <= {pin_filt_ff[0], shift_ff[15:1]};
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bit_cnt_ff <= 5'h00;
		end else if (!cs_active) begin
			bit_cnt_ff <= 5'h00;
		end else if (sclk_rise && bit_cnt_ff <= `CT_SPI_FRAME_BITS) begin
			// saturate past a full frame so long frames are dropped
			bit_cnt_ff <= bit_cnt_ff + 5'h01;
		end
	end

	// read data leaves on falling edges during the second byte
	assign rd_sel = read_mux(shift_ff[14:8], timer_ff, hwcfg_ff);

	// captured once so a write landing mid-read cannot tear the byte
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_ff <= 8'h00;
		end else if (sclk_fall && bit_cnt_ff == `CT_SPI_ADDR_BITS) begin
			rd_data_ff <= rd_sel;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			miso_ff <= 1'b0;
		end else if (!cs_active) begin
			miso_ff <= 1'b0;
		end else if (sclk_fall) begin
			if (bit_cnt_ff == `CT_SPI_ADDR_BITS) begin
				miso_ff <= rd_sel[0];
			end else if (bit_cnt_ff > `CT_SPI_ADDR_BITS && bit_cnt_ff < `CT_SPI_FRAME_BITS) begin
				miso_ff <= rd_data_ff[bit_cnt_ff[2:0]];
			end
		end
	end

	assign spi_miso_out    = miso_ff;
	assign spi_miso_en_out = cs_active;

	// writes commit only on the closing chip select edge of a whole frame
	assign wr_addr   = shift_ff[6:0];
	assign wr_data   = shift_ff[15:8];
	assign wr_commit = cs_rise && (bit_cnt_ff == `CT_SPI_FRAME_BITS) &&
	                   shift_ff[`CT_SPI_WR_BIT];

	assign cyc_sense_sel = (gpio_config_in == `CT_GPIO_CYC_SENSE);
	assign sense_clear   = restart_mode_in && cyc_sense_sel &&
	                       gpio_high_side_cleared_in;

	// level-1 lock only arms on a chip select rise, never released
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lock_one_eff_ff <= 1'b0;
		end else if (cs_rise && lock_one_in) begin
			lock_one_eff_ff <= 1'b1;
		end
	end

	// the restart clear outranks soft reset and any write in the same cycle
	always_comb begin
		nxt_timer = timer_ff;
		if (sense_clear) begin
			nxt_timer = `CT_TIMER_RST;
		end else if (soft_reset_in) begin
			nxt_timer = `CT_TIMER_RST;
		end else if (wr_commit && wr_addr == `CT_ADDR_TIMER) begin
			nxt_timer = {1'b0, wr_data[`CT_ON_HI:`CT_PER_LO]};
		end
	end

	// restart mode freezes the whole register, writes included
	always_comb begin
		nxt_hwcfg = hwcfg_ff;
		if (restart_mode_in) begin
			nxt_hwcfg = hwcfg_ff;
		end else if (soft_reset_in) begin
			nxt_hwcfg = `CT_HWCFG_RST;
			if (lock_one_eff_ff) begin
				nxt_hwcfg[`CT_HYS_BIT]  = hwcfg_ff[`CT_HYS_BIT];
				nxt_hwcfg[`CT_TSD_BIT]  = hwcfg_ff[`CT_TSD_BIT];
				nxt_hwcfg[`CT_RDEL_BIT] = hwcfg_ff[`CT_RDEL_BIT];
			end
			// a set level-0 lock stays set across a soft reset
			nxt_hwcfg[`CT_LOCK0_BIT] = hwcfg_ff[`CT_LOCK0_BIT];
		end else if (wr_commit && wr_addr == `CT_ADDR_HWCFG) begin
			nxt_hwcfg[`CT_LOCK0_BIT] = wr_data[`CT_LOCK0_BIT];
			if (!lock_one_eff_ff) begin
				nxt_hwcfg[`CT_HYS_BIT]  = wr_data[`CT_HYS_BIT];
				nxt_hwcfg[`CT_TSD_BIT]  = wr_data[`CT_TSD_BIT];
				nxt_hwcfg[`CT_RDEL_BIT] = wr_data[`CT_RDEL_BIT];
			end
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			timer_ff <= `CT_TIMER_RST;
		end else begin
			timer_ff <= nxt_timer;
		end
	end

	// rewriting the same code still restarts the period from its on phase
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			timer_changed_ff <= 1'b0;
		end else begin
			timer_changed_ff <= (nxt_timer != timer_ff) ||
			                    (wr_commit && wr_addr == `CT_ADDR_TIMER);
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hwcfg_ff <= `CT_HWCFG_RST;
		end else begin
			hwcfg_ff <= nxt_hwcfg;
		end
	end

	cyclic_wave_gen #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_wave (
		.clock_in         (clock_in),
		.rst_n_in         (rst_n_in),
		.run_in           (timer_assigned_in),
		.restart_in       (timer_changed_ff),
		.on_code_in       (timer_ff[`CT_ON_HI:`CT_ON_LO]),
		.per_code_in      (timer_ff[`CT_PER_HI:`CT_PER_LO]),
		.high_side_out    (gen_high),
		.period_start_out (gen_start)
	);

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			high_side_output_out <= 1'b0;
		end else begin
			high_side_output_out <= gen_high;
		end
	end

	// wake ticks run alongside the sense switch, neither gates the other
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cyclic_wake_tick_out <= 1'b0;
		end else begin
			cyclic_wake_tick_out <= gen_start && timer_wake_enable_in;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cyclic_sense_active_out <= 1'b0;
		end else begin
			cyclic_sense_active_out <= cyc_sense_sel && timer_assigned_in;
		end
	end

	// config bits go straight out; their users sit outside this block
	assign undervoltage_release_hysteresis_out = hwcfg_ff[`CT_HYS_BIT];
	assign overtemp_retry_extension_out        = hwcfg_ff[`CT_TSD_BIT];
	assign reset_delay_select_out              = hwcfg_ff[`CT_RDEL_BIT];
	assign level0_lock_out                     = hwcfg_ff[`CT_LOCK0_BIT];
	assign protected_write_enable_out          = !hwcfg_ff[`CT_LOCK0_BIT];
	assign level1_lock_active_out              = lock_one_eff_ff;

endmodule : cyclic_timer_and_hw_lock_cfg

// ===== sim/host_spi_master.sv
// host microcontroller model acting as spi master for the config block
`timescale 1ns/1ps

module host_spi_master #(
	parameter int HALF = 6,
	parameter int GAP  = 8
) (
	input  wire logic clock_in,
	input  wire logic spi_miso_in,
	output logic      chip_select_n_out,
	output logic      spi_clk_out,
	output logic      spi_mosi_out
);
	initial begin
		chip_select_n_out = 1'b1;
		spi_clk_out       = 1'b0;
		spi_mosi_out      = 1'b0;
	end

	// one 16 bit frame, lsb first; sclk stands still low outside frames
	task automatic xfer(input logic [6:0] addr, input logic wr, input logic [7:0] wdata,
			output logic [7:0] rdata);
		logic [15:0] frame;
		frame = {wdata, wr, addr};
		rdata = 8'h00;
		@(posedge clock_in);
		chip_select_n_out <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			@(posedge clock_in);
			spi_mosi_out <= frame[i];
			repeat (HALF) @(posedge clock_in);
			// miso settled long before this rise, so sampling here is race free
			if (i >= 8) rdata[i-8] = spi_miso_in;
			spi_clk_out <= 1'b1;
			repeat (HALF) @(posedge clock_in);
			spi_clk_out <= 1'b0;
		end
		repeat (HALF) @(posedge clock_in);
		chip_select_n_out <= 1'b1;
		// deselected line shows the inverse rather than a stale bit
		spi_mosi_out <= ~frame[15];
		repeat (GAP) @(posedge clock_in);
	endtask : xfer
endmodule : host_spi_master

// ===== sim/cyclic_cfg_props.sv
// assertion checker for the cyclic timer and hardware lock config block
`timescale 1ns/1ps

module cyclic_cfg_props #(
	parameter int TICK_CYCLES = 4
) (
	input wire logic       clock_in,
	input wire logic       rst_n_in,
	input wire logic       chip_select_n_in,
	input wire logic       timer_wake_enable_in,
	input wire logic       timer_assigned_in,
	input wire logic       restart_mode_in,
	input wire logic [2:0] gpio_config_in,
	input wire logic       gpio_high_side_cleared_in,
	input wire logic       lock_one_in,
	input wire logic       spi_miso_en_out,
	input wire logic       high_side_output_out,
	input wire logic       cyclic_wake_tick_out,
	input wire logic       cyclic_sense_active_out,
	input wire logic       undervoltage_release_hysteresis_out,
	input wire logic       overtemp_retry_extension_out,
	input wire logic       reset_delay_select_out,
	input wire logic       level0_lock_out,
	input wire logic       level1_lock_active_out,
	input wire logic       protected_write_enable_out
);
	default clocking dc @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	prot_enable_a: assert property (protected_write_enable_out == !level0_lock_out)
		else $error("protected write enable not inverse of level-0 lock");
	cfg_quiet_a: assert property (($changed(undervoltage_release_hysteresis_out) ||
		$changed(level0_lock_out)) |-> $past(chip_select_n_in, 2))
		else $error("config bit changed while chip select low");
	lock_hold_a: assert property (level1_lock_active_out && $past(level1_lock_active_out)
		|-> $stable(undervoltage_release_hysteresis_out) && $stable(overtemp_retry_extension_out)
		&& $stable(reset_delay_select_out)) else $error("locked config bit changed");
	lock_sticky_a: assert property (level1_lock_active_out |=> level1_lock_active_out)
		else $error("level-1 lock released before power-up");
	lock_arm_a: assert property ($rose(level1_lock_active_out) |->
		$past(lock_one_in) && $past(chip_select_n_in)) else $error("lock armed without cause");
	restart_clear_a: assert property (restart_mode_in && gpio_config_in == 3'h3 &&
		gpio_high_side_cleared_in |-> ##[1:6] !high_side_output_out)
		else $error("timer not cleared in restart");
	wake_pulse_a: assert property (cyclic_wake_tick_out |-> $past(timer_wake_enable_in)
		##1 !cyclic_wake_tick_out) else $error("wake tick without enable or too long");
	wake_align_a: assert property (cyclic_wake_tick_out |-> ##[0:2] high_side_output_out)
		else $error("period start without high side on-time");
	sense_flag_a: assert property (cyclic_sense_active_out == ($past(gpio_config_in) == 3'h3
		&& $past(timer_assigned_in))) else $error("cyclic sense flag wrong");
	miso_idle_a: assert property (chip_select_n_in [*6] |-> !spi_miso_en_out)
		else $error("miso driven while deselected");

	cover property ($rose(level1_lock_active_out));
	cover property (cyclic_wake_tick_out);
	cover property ($rose(high_side_output_out));
endmodule : cyclic_cfg_props

bind cyclic_timer_and_hw_lock_cfg cyclic_cfg_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
	.clock_in(clock_in), .rst_n_in(rst_n_in), .chip_select_n_in(chip_select_n_in),
	.timer_wake_enable_in(timer_wake_enable_in), .timer_assigned_in(timer_assigned_in),
	.restart_mode_in(restart_mode_in), .gpio_config_in(gpio_config_in),
	.gpio_high_side_cleared_in(gpio_high_side_cleared_in), .lock_one_in(lock_one_in),
	.spi_miso_en_out(spi_miso_en_out), .high_side_output_out(high_side_output_out),
	.cyclic_wake_tick_out(cyclic_wake_tick_out), .cyclic_sense_active_out(cyclic_sense_active_out),
	.undervoltage_release_hysteresis_out(undervoltage_release_hysteresis_out),
	.overtemp_retry_extension_out(overtemp_retry_extension_out),
	.reset_delay_select_out(reset_delay_select_out), .level0_lock_out(level0_lock_out),
	.level1_lock_active_out(level1_lock_active_out),
	.protected_write_enable_out(protected_write_enable_out));

// ===== sim/cyclic_timer_and_hw_lock_cfg_tb.sv
// testbench for the cyclic timer and hardware lock config block
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

module cyclic_timer_and_hw_lock_cfg_tb;
	localparam int TK = 4;
	logic clock_in = 1'b0, rst_n_in = 1'b0, cs_n, sclk, mosi, miso, miso_en;
	logic assigned = 1'b0, wake_en = 1'b0, restart = 1'b0, soft_rst = 1'b0;
	logic hs_cleared = 1'b0, lock_one = 1'b0;
	logic [2:0] gpio = 3'h0;
	logic hs, tick, sense, hys, tsd, rdel, lock0, lock1, prot_we, wake_seen = 1'b0;
	logic [7:0] rd_val;
	int fail_count = 0, num_checks = 0;
	int on_t[1:5] = '{1, 3, 10, 100, 200};
	int per_t[0:3] = '{100, 200, 500, 1000};

	always #2 clock_in = ~clock_in;
	always @(posedge clock_in) if (tick === 1'b1) wake_seen <= 1'b1;

	host_spi_master u_host_spi_master (.clock_in(clock_in), .spi_miso_in(miso),
		.chip_select_n_out(cs_n), .spi_clk_out(sclk), .spi_mosi_out(mosi));

	cyclic_timer_and_hw_lock_cfg #(.TICK_CYCLES(TK)) u_cyclic_timer_and_hw_lock_cfg (
		.clock_in(clock_in), .rst_n_in(rst_n_in), .chip_select_n_in(cs_n),
		.spi_clk_in(sclk), .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_en_out(miso_en),
		.timer_assigned_in(assigned), .timer_wake_enable_in(wake_en),
		.restart_mode_in(restart), .soft_reset_in(soft_rst), .gpio_config_in(gpio),
		.gpio_high_side_cleared_in(hs_cleared), .lock_one_in(lock_one),
		.high_side_output_out(hs), .cyclic_wake_tick_out(tick),
		.cyclic_sense_active_out(sense), .undervoltage_release_hysteresis_out(hys),
		.overtemp_retry_extension_out(tsd), .reset_delay_select_out(rdel),
		.level0_lock_out(lock0), .level1_lock_active_out(lock1),
		.protected_write_enable_out(prot_we));

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		u_host_spi_master.xfer(a, 1'b1, d, rd_val);
	endtask : wr

	task automatic rd_chk(input logic [6:0] a, input logic [7:0] e, input string nm);
		u_host_spi_master.xfer(a, 1'b0, 8'h00, rd_val);
		`CHECK(nm, e, rd_val)
	endtask : rd_chk

	task automatic soft_pulse();
		@(posedge clock_in);
		soft_rst <= 1'b1;
		@(posedge clock_in);
		soft_rst <= 1'b0;
		repeat (4) @(posedge clock_in);
	endtask : soft_pulse

	// skips the pulse in flight, then times one whole on-time and period
	task automatic pulse_chk(input int on_cyc, input int per_cyc);
		int hi, tot;
		hi = 0;
		tot = 0;
		while (hs === 1'b1 && tot < 20000) begin @(posedge clock_in); tot++; end
		while (hs !== 1'b1 && tot < 20000) begin @(posedge clock_in); tot++; end
		while (hs === 1'b1 && hi < 20000) begin @(posedge clock_in); hi++; end
		tot = hi;
		while (hs !== 1'b1 && tot < 20000) begin @(posedge clock_in); tot++; end
		`CHECK("on_width", on_cyc, hi)
		`CHECK("period", per_cyc, tot)
	endtask : pulse_chk

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : results

	initial begin
		repeat (90000) @(posedge clock_in);
		fail_count++;
		$display("MISMATCH watchdog expected done seen hang");
		results();
	end

	initial begin
		repeat (5) @(posedge clock_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge clock_in);
		rd_chk(7'h0c, 8'h00, "timer_reset");
		rd_chk(7'h0e, 8'h00, "hwcfg_reset");
		`CHECK("rdel_default", 1'b0, rdel)
		`CHECK("prot_reset", 1'b1, prot_we)
		wr(7'h0c, 8'hff);
		rd_chk(7'h0c, 8'h7f, "timer_reserved");
		`CHECK("hs_reserved_code", 1'b0, hs)
		wr(7'h0e, 8'hff);
		rd_chk(7'h0e, 8'hb8, "hwcfg_reserved");
		`CHECK("hys", 1'b1, hys)
		`CHECK("tsd", 1'b1, tsd)
		`CHECK("rdel", 1'b1, rdel)
		`CHECK("lock0", 1'b1, lock0)
		`CHECK("prot_locked", 1'b0, prot_we)
		wr(7'h0e, 8'h08);
		rd_chk(7'h0e, 8'h08, "lock0_scope");
		wr(7'h0d, 8'hff);
		rd_chk(7'h0d, 8'h00, "unmapped");
		wr(7'h0c, 8'h63);
		soft_pulse();
		rd_chk(7'h0c, 8'h00, "timer_soft");
		rd_chk(7'h0e, 8'h08, "lock0_soft");
		// write a running code first, then assign; unassigned must stay quiet
		wr(7'h0c, 8'h13);
		for (int i = 0; i < 60; i++) begin
			@(posedge clock_in);
			`CHECK("hs_unassigned", 1'b0, hs)
		end
		assigned <= 1'b1;
		wr(7'h0c, 8'h60);
		`CHECK("hs_static_high", 1'b1, hs)
		wr(7'h0c, 8'h00);
		`CHECK("hs_static_low", 1'b0, hs)
		wake_en <= 1'b1;
		gpio <= 3'h3;
		for (int k = 1; k <= 5; k++) begin
			wr(7'h0c, {1'b0, 3'(k), 4'h3});
			pulse_chk(on_t[k] * TK, per_t[3] * TK);
		end
		`CHECK("sense_active", 1'b1, sense)
		`CHECK("wake_seen", 1'b1, wake_seen)
		for (int p = 0; p < 3; p++) begin
			wr(7'h0c, {4'h1, 4'(p)});
			pulse_chk(TK, per_t[p] * TK);
		end
		wr(7'h0c, 8'h13);
		restart <= 1'b1;
		repeat (10) @(posedge clock_in);
		restart <= 1'b0;
		rd_chk(7'h0c, 8'h13, "restart_keep");
		restart <= 1'b1;
		hs_cleared <= 1'b1;
		repeat (10) @(posedge clock_in);
		restart <= 1'b0;
		hs_cleared <= 1'b0;
		rd_chk(7'h0c, 8'h00, "restart_clear");
		rd_chk(7'h0e, 8'h08, "hwcfg_restart");
		wr(7'h0e, 8'hb0);
		lock_one <= 1'b1;
		wr(7'h0e, 8'hb8);
		`CHECK("lock1_armed", 1'b1, lock1)
		wr(7'h0e, 8'h00);
		rd_chk(7'h0e, 8'hb0, "lock1_guard");
		soft_pulse();
		rd_chk(7'h0e, 8'hb0, "lock1_soft");
		lock_one <= 1'b0;
		wr(7'h0e, 8'h00);
		`CHECK("lock1_sticky", 1'b1, lock1)
		results();
	end
endmodule : cyclic_timer_and_hw_lock_cfg_tb
